/* ctu_pkg.sv */
// Constants, types and helper functions of the control transfer unit.
// Assumes a 32-bit instruction word and a 32-bit program counter.
`default_nettype none
package ctu_pkg;
    localparam int          XLEN          = 32;
    localparam logic [6:0]  OPC_JAL       = 7'h6F;
    localparam logic [6:0]  OPC_JALR      = 7'h67;
    localparam logic [6:0]  OPC_BRANCH    = 7'h63;
    localparam logic [2:0]  F3_EQ         = 3'h0;
    localparam logic [2:0]  F3_NE         = 3'h1;
    localparam logic [2:0]  F3_LT         = 3'h4;
    localparam logic [2:0]  F3_GE         = 3'h5;
    localparam logic [2:0]  F3_LTU        = 3'h6;
    localparam logic [2:0]  F3_GEU        = 3'h7;
    localparam logic [4:0]  ZERO_REG      = 5'h00;
    localparam logic [4:0]  LINK_REG_PRI  = 5'h01;
    localparam logic [4:0]  LINK_REG_ALT  = 5'h05;
    localparam logic [31:0] INSTR_STEP    = 32'h0000_0004;
    // Register offsets (byte addresses)
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_MASK     = 12'h008;
    localparam logic [11:0] ADDR_COUNT    = 12'h00C;
    localparam logic [11:0] ADDR_LAST_TGT = 12'h010;
    // Field positions
    localparam int          CTRL_EN_BIT   = 0;
    localparam int          CTRL_CMP_BIT  = 1;
    localparam int          ST_XFER_BIT   = 0;
    localparam int          ST_MISAL_BIT  = 1;
    localparam int          ST_FAULT_BIT  = 2;
    localparam int          ST_W          = 3;
    // Reset values
    localparam logic [1:0]  CTRL_RST      = 2'h1;
    localparam logic [2:0]  MASK_RST      = 3'h0;
    localparam logic [2:0]  STATUS_RST    = 3'h0;

    typedef enum logic [1:0] {
        CTU_OP_NONE = 2'b00,
        CTU_OP_JAL  = 2'b01,
        CTU_OP_JALR = 2'b11,
        CTU_OP_BR   = 2'b10
    } ctu_op_e;

    function automatic logic [31:0] ctu_imm_i(input logic [31:0] ins);
        return {{20{ins[31]}}, ins[31:20]};
    endfunction

    function automatic logic [31:0] ctu_imm_j(input logic [31:0] ins);
        return {{11{ins[31]}}, ins[31], ins[19:12], ins[20],
                ins[30:21], 1'b0};
    endfunction

    function automatic logic [31:0] ctu_imm_b(input logic [31:0] ins);
        return {{19{ins[31]}}, ins[31], ins[7], ins[30:25],
                ins[11:8], 1'b0};
    endfunction

    function automatic logic ctu_is_link(input logic [4:0] r);
        return (r == LINK_REG_PRI) || (r == LINK_REG_ALT);
    endfunction
endpackage
`default_nettype wire

/* ctu_ras_hint.sv */
// Return-address-stack hint decode from link-register usage.
// Assumes the caller qualifies the result with a valid jump.
`default_nettype none
module ctu_ras_hint
    import ctu_pkg::*;
(
    input  wire logic       is_jal,
    input  wire logic       is_jalr,
    input  wire logic [4:0] rd,
    input  wire logic [4:0] rs1,
    output logic            push,
    output logic            pop
);
    logic rd_link;
    logic rs_link;

    assign rd_link = ctu_is_link(rd);
    assign rs_link = ctu_is_link(rs1);

    always_comb begin
        push = 1'b0;
        pop  = 1'b0;
        if (is_jal) begin
            push = rd_link;
        end else if (is_jalr) begin
            push = rd_link;
            pop  = rs_link && (!rd_link || rd != rs1);
        end
    end
endmodule
`default_nettype wire

/* ctu_top.sv */
// Control transfer unit: jump and branch outcome, link value,
// misalignment check and return-stack hints, with an APB register file.
// Assumes issue and fault inputs come from logic on pclk.
//
// Notes on behaviour
// - Direct jump target is pc plus sign-extended J offset in halfwords.
// - Direct jump writes pc plus 4 to its destination.
// - Destination zero register discards the link; nothing is written.
// - Indirect jump adds unscaled 12-bit offset to source, clears bit 0.
// - Indirect jump writes pc plus 4; zero destination discards it.
// - Both jumps flag misalignment when target is not word aligned.
// - With halfword instructions enabled, misalignment is never flagged.
// - Direct jump pushes return stack only for a link destination.
// - Indirect jump pops, pushes or both by link register usage.
// - Branch target is pc plus sign-extended B offset in halfwords.
// - Equal branch taken on equal sources; not-equal on differing.
// - Less-than branches compare signed or unsigned.
// - Greater-or-equal branches compare signed or unsigned.
// - Branch misalignment is flagged only when taken.
// - No delay slot: younger instructions are flushed on redirect.
// - A fetch fault on a target is reported at the target address.
`default_nettype none
module ctu_top
    import ctu_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        issue_valid,
    input  wire logic [31:0] issue_pc,
    input  wire logic [31:0] issue_instr,
    input  wire logic [31:0] issue_src_a,
    input  wire logic [31:0] issue_src_b,
    input  wire logic        fetch_fault,
    input  wire logic [31:0] fetch_fault_pc,
    output logic             res_valid,
    output logic             res_taken,
    output logic             res_misaligned,
    output logic             res_redirect,
    output logic             res_flush,
    output logic      [31:0] res_target,
    output logic      [31:0] res_next_pc,
    output logic             res_link_we,
    output logic      [4:0]  res_link_rd,
    output logic      [31:0] res_link_data,
    output logic             res_ras_push,
    output logic             res_ras_pop,
    output logic             fault_valid,
    output logic      [31:0] fault_pc
);
    // Register state
    logic [1:0]  ctrl_reg;
    logic [2:0]  mask_reg;
    logic [2:0]  status_reg;
    logic [2:0]  status_next;
    logic [31:0] count_reg;
    logic [31:0] last_tgt_reg;
    logic [31:0] prdata_reg;

    // Decode
    ctu_op_e     op;
    logic [4:0]  rd;
    logic [4:0]  rs1;
    logic [2:0]  f3;
    logic        fire;
    logic        cond;
    logic        taken;
    logic        misal;
    logic [31:0] target;
    logic [31:0] seq_pc;
    logic        hint_push;
    logic        hint_pop;
    logic        cmp_en;

    assign rd     = issue_instr[11:7];
    assign rs1    = issue_instr[19:15];
    assign f3     = issue_instr[14:12];
    assign cmp_en = ctrl_reg[CTRL_CMP_BIT];
    assign fire   = issue_valid && ctrl_reg[CTRL_EN_BIT] &&
                    (op != CTU_OP_NONE);
    assign seq_pc = issue_pc + INSTR_STEP;

    always_comb begin
        case (issue_instr[6:0])
            OPC_JAL:    op = CTU_OP_JAL;
            OPC_JALR:   op = CTU_OP_JALR;
            OPC_BRANCH: op = CTU_OP_BR;
            default:    op = CTU_OP_NONE;
        endcase
    end

    always_comb begin
        case (f3)
            F3_EQ:   cond = issue_src_a == issue_src_b;
            F3_NE:   cond = issue_src_a != issue_src_b;
            F3_LT:   cond = $signed(issue_src_a) <
                            $signed(issue_src_b);
            F3_LTU:  cond = issue_src_a < issue_src_b;
            F3_GE:   cond = $signed(issue_src_a) >=
                            $signed(issue_src_b);
            F3_GEU:  cond = issue_src_a >= issue_src_b;
            default: cond = 1'b0;
        endcase
    end

    always_comb begin
        case (op)
            CTU_OP_JAL:  target = issue_pc + ctu_imm_j(issue_instr);
            CTU_OP_JALR: target = (issue_src_a + ctu_imm_i(issue_instr))
                                  & ~32'h0000_0001;
            CTU_OP_BR:   target = issue_pc + ctu_imm_b(issue_instr);
            default:     target = seq_pc;
        endcase
    end

    assign taken = (op == CTU_OP_BR) ? cond : (op != CTU_OP_NONE);
    // Halfword mode never flags; otherwise only a taken transfer may
    assign misal = taken && !cmp_en && (target[1:0] != 2'h0);

    ctu_ras_hint u_ras (
        .is_jal  (op == CTU_OP_JAL),
        .is_jalr (op == CTU_OP_JALR),
        .rd      (rd),
        .rs1     (rs1),
        .push    (hint_push),
        .pop     (hint_pop)
    );

    // Result stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid      <= 1'b0;
            res_taken      <= 1'b0;
            res_misaligned <= 1'b0;
            res_redirect   <= 1'b0;
            res_ras_push   <= 1'b0;
            res_ras_pop    <= 1'b0;
        end else begin
            res_valid      <= fire;
            res_taken      <= fire && taken;
            res_misaligned <= fire && misal;
            res_redirect   <= fire && taken && !misal;
            res_ras_push   <= fire && hint_push;
            res_ras_pop    <= fire && hint_pop;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_link_we   <= 1'b0;
            res_link_rd   <= ZERO_REG;
            res_link_data <= 32'h0000_0000;
        end else begin
            // Zero destination or a faulting jump leaves the file alone
            res_link_we   <= fire && (op != CTU_OP_BR) && !misal &&
                             (rd != ZERO_REG);
            res_link_rd   <= fire ? rd : ZERO_REG;
            if (fire) begin
                res_link_data <= seq_pc;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_target  <= 32'h0000_0000;
            res_next_pc <= 32'h0000_0000;
        end else if (fire) begin
            res_target  <= target;
            res_next_pc <= (taken && !misal) ? target : seq_pc;
        end
    end

    // Flush of younger work behind a taken transfer that is not misaligned
    assign res_flush = res_redirect;

    // Fetch faults belong to the instruction at the faulting address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_valid <= 1'b0;
            fault_pc    <= 32'h0000_0000;
        end else begin
            fault_valid <= fetch_fault;
            if (fetch_fault) begin
                fault_pc <= fetch_fault_pc;
            end
        end
    end

    // APB slave, zero wait states
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic hit;

    assign acc    = psel && penable;
    assign wr_acc = acc && pwrite;
    assign rd_acc = acc && !pwrite;
    assign hit    = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                    (paddr == ADDR_MASK) || (paddr == ADDR_COUNT) ||
                    (paddr == ADDR_LAST_TGT);
    assign pready  = 1'b1;
    assign pslverr = acc && !hit;
    assign prdata  = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
            mask_reg <= MASK_RST;
        end else if (wr_acc) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_reg <= pwdata[1:0];
            end
            if (paddr == ADDR_MASK) begin
                mask_reg <= pwdata[ST_W-1:0];
            end
        end
    end

    // Read data is captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_CTRL:     prdata_reg <= {30'h0, ctrl_reg};
                ADDR_STATUS:   prdata_reg <= {29'h0, status_reg};
                ADDR_MASK:     prdata_reg <= {29'h0, mask_reg};
                ADDR_COUNT:    prdata_reg <= count_reg;
                ADDR_LAST_TGT: prdata_reg <= last_tgt_reg;
                default:       prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Sticky events; a read clears only what it returned, a set wins
    logic [2:0] ev_set;
    logic [2:0] ev_clr;

    always_comb begin
        ev_set = 3'h0;
        ev_set[ST_XFER_BIT]  = fire && taken && !misal;
        ev_set[ST_MISAL_BIT] = fire && misal;
        ev_set[ST_FAULT_BIT] = fetch_fault;
        ev_clr = (rd_acc && paddr == ADDR_STATUS) ?
                 prdata_reg[ST_W-1:0] : 3'h0;
        status_next = (status_reg & ~ev_clr) | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= STATUS_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_next & mask_reg);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg    <= 32'h0000_0000;
            last_tgt_reg <= 32'h0000_0000;
        end else if (fire && taken && !misal) begin
            count_reg    <= count_reg + 32'h0000_0001;
            last_tgt_reg <= target;
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_fire_op(ctu_op_e o);
        fire && op == o;
    endsequence

    a_jal_target: assert property (s_fire_op(CTU_OP_JAL) |=>
        res_target == $past(issue_pc) + ctu_imm_j($past(issue_instr)))
        else $error("jump target wrong");
    a_link_value: assert property (fire && op != CTU_OP_BR |=>
        res_link_data == $past(issue_pc) + INSTR_STEP)
        else $error("link value wrong");
    a_zero_dest: assert property (res_link_we |->
        res_link_rd != ZERO_REG)
        else $error("write to zero register");
    a_jalr_target: assert property (s_fire_op(CTU_OP_JALR) |=>
        res_target[0] == 1'b0 && res_target[31:1] ==
        ($past(issue_src_a) + ctu_imm_i($past(issue_instr))) >> 1)
        else $error("indirect target wrong");
    a_jump_misal: assert property (fire && op != CTU_OP_BR &&
        !cmp_en && target[1] |=> res_misaligned && !res_link_we)
        else $error("jump misalignment missed");
    a_half_mode: assert property (fire && cmp_en |=>
        !res_misaligned)
        else $error("misalignment in halfword mode");
    a_jal_hint: assert property (s_fire_op(CTU_OP_JAL) |=>
        res_ras_push == ctu_is_link($past(rd)) && !res_ras_pop)
        else $error("direct jump hint wrong");
    a_br_target: assert property (s_fire_op(CTU_OP_BR) |=>
        res_target == $past(issue_pc) + ctu_imm_b($past(issue_instr)))
        else $error("branch target wrong");
    a_beq_taken: assert property (s_fire_op(CTU_OP_BR) && f3 == F3_EQ |=>
        res_taken == ($past(issue_src_a) == $past(issue_src_b)))
        else $error("equal branch wrong");
    a_bltu_taken: assert property (s_fire_op(CTU_OP_BR) && f3 == F3_LTU
        |=> res_taken == ($past(issue_src_a) < $past(issue_src_b)))
        else $error("unsigned less-than wrong");
    a_bge_taken: assert property (s_fire_op(CTU_OP_BR) && f3 == F3_GE
        |=> res_taken == ($signed($past(issue_src_a)) >=
        $signed($past(issue_src_b))))
        else $error("signed greater-equal wrong");
    a_untaken_clean: assert property (res_valid && !res_taken |->
        !res_misaligned && !res_redirect)
        else $error("untaken branch flagged");
    a_flush_redirect: assert property (res_redirect |->
        res_flush && res_next_pc == res_target)
        else $error("redirect without flush");
    a_fault_target: assert property (fetch_fault |=>
        fault_valid && fault_pc == $past(fetch_fault_pc))
        else $error("fault not at target");
    a_seq_next: assert property (fire && !(taken && !misal) |=>
        res_next_pc == $past(issue_pc) + INSTR_STEP && !res_redirect)
        else $error("sequential pc wrong");
endmodule
`default_nettype wire

/* ctu_fetch_model.sv */
// Fetch-side partner: refetches the target after a redirect and can
// report a fetch fault on it. Assumes the same pclk as the unit.
`default_nettype none
module ctu_fetch_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        fault_arm,
    input  wire logic        res_redirect,
    input  wire logic [31:0] res_next_pc,
    output logic             fetch_fault,
    output logic      [31:0] fetch_fault_pc
);
    timeunit 1ns;
    timeprecision 1ps;
    // Address is only meaningful with the pulse; it churns otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_fault    <= 1'b0;
            fetch_fault_pc <= 32'h0000_0000;
        end else begin
            fetch_fault    <= fault_arm & res_redirect;
            fetch_fault_pc <= (fault_arm & res_redirect) ? res_next_pc
                                                         : ~fetch_fault_pc;
        end
    end
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the control transfer unit.
// Assumes ctu_pkg, ctu_top and ctu_fetch_model are compiled first.
`default_nettype none
`define CHK(got, exp) \
    begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
    end end
module tb
    import ctu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, fault_arm;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, fetch_fault_pc, fault_pc, rd_data;
    logic        pready, pslverr, irq, fetch_fault, fault_valid;
    logic        issue_valid, hw_mode, err;
    logic [31:0] issue_pc, issue_instr, issue_src_a, issue_src_b;
    logic        res_valid, res_taken, res_misaligned, res_redirect;
    logic        res_flush, res_link_we, res_ras_push, res_ras_pop;
    logic [31:0] res_target, res_next_pc, res_link_data;
    logic [4:0]  res_link_rd;
    logic [2:0]  f3s [6];
    int          n_mismatch, check_count, n_clean;
    // Expected taken flags per comparison, indexed like f3s
    localparam logic [5:0] TK_NEG = 6'b100110;
    localparam logic [5:0] TK_EQ  = 6'b101001;

    ctu_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .issue_valid,
        .issue_pc, .issue_instr, .issue_src_a, .issue_src_b, .fetch_fault,
        .fetch_fault_pc, .res_valid, .res_taken, .res_misaligned,
        .res_redirect, .res_flush, .res_target, .res_next_pc, .res_link_we,
        .res_link_rd, .res_link_data, .res_ras_push, .res_ras_pop,
        .fault_valid, .fault_pc);
    ctu_fetch_model fetch (.pclk, .presetn, .fault_arm, .res_redirect,
        .res_next_pc, .fetch_fault, .fetch_fault_pc);

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end else begin
            rd_data = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd_data, e)
    endtask

    // Presents one instruction, then checks the outcome one edge later
    task automatic iss(input logic [31:0] pc, ins, a, b,
                       input logic tk, input logic [31:0] tgt,
                       input logic pu, po);
        logic mis, rdr, lw;
        mis = tk & ~hw_mode & (tgt[1:0] != 2'h0);
        rdr = tk & ~mis;
        lw = (ins[6:0] != OPC_BRANCH) & ~mis & (ins[11:7] != ZERO_REG);
        n_clean += int'(rdr);
        @(posedge pclk);
        issue_valid <= 1'b1;
        issue_pc <= pc;
        issue_instr <= ins;
        issue_src_a <= a;
        issue_src_b <= b;
        @(posedge pclk);
        issue_valid <= 1'b0;
        issue_instr <= ~ins;
        #1;
        `CHK({res_valid, res_taken, res_misaligned, res_redirect, res_flush,
              res_link_we, res_ras_push, res_ras_pop},
             {1'b1, tk, mis, rdr, rdr, lw, pu, po})
        `CHK(res_target, tgt)
        `CHK(res_next_pc, rdr ? tgt : pc + INSTR_STEP)
        if (lw) `CHK({res_link_rd, res_link_data}, {ins[11:7], pc + 32'h4})
    endtask

    function automatic logic [31:0] j_ins(input logic [4:0] rd,
                                          input logic [20:0] o);
        return {o[20], o[10:1], o[11], o[19:12], rd, OPC_JAL};
    endfunction
    function automatic logic [31:0] i_ins(input logic [4:0] rd, rs,
                                          input logic [11:0] o);
        return {o, rs, 3'h0, rd, OPC_JALR};
    endfunction
    function automatic logic [31:0] b_ins(input logic [2:0] f,
                                          input logic [12:0] o);
        return {o[12], o[10:5], 5'h02, 5'h01, f, o[4:1], o[11], OPC_BRANCH};
    endfunction

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        issue_valid = 1'b0;
        issue_pc = 32'h0;
        issue_instr = 32'h0;
        issue_src_a = 32'h0;
        issue_src_b = 32'h0;
        fault_arm = 1'b0;
        hw_mode = 1'b0;
        n_mismatch = 0;
        check_count = 0;
        n_clean = 0;
        f3s = '{F3_EQ, F3_NE, F3_LT, F3_GE, F3_LTU, F3_GEU};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CTRL, {30'h0, CTRL_RST});
        rd(ADDR_MASK, {29'h0, MASK_RST});
        apb(1'b1, ADDR_STATUS, 32'h7);
        rd(ADDR_STATUS, {29'h0, STATUS_RST});
        apb(1'b0, 12'h020, 32'h0);
        `CHK({err, rd_data}, {1'b1, 32'h0})
        iss(32'h100, j_ins(LINK_REG_PRI, 21'h8), 0, 0, 1, 32'h108, 1, 0);
        iss(32'h1000, j_ins(ZERO_REG, 21'h1FF800), 0, 0, 1, 32'h800, 0, 0);
        iss(32'h200, j_ins(LINK_REG_ALT, 21'h6), 0, 0, 1, 32'h206, 1, 0);
        iss(32'h300, j_ins(5'h02, 21'h10), 0, 0, 1, 32'h310, 0, 0);
        iss(32'h400, i_ins(5'h00, 5'h02, 12'h001), 32'h2004, 0, 1, 32'h2004, 0, 0);
        iss(32'h404, i_ins(5'h00, 5'h01, 12'hFFF), 32'h2005, 0, 1, 32'h2004, 0, 1);
        iss(32'h408, i_ins(5'h05, 5'h02, 12'h7FF), 32'h1001, 0, 1, 32'h1800, 1, 0);
        iss(32'h40C, i_ins(5'h01, 5'h05, 12'h800), 32'h3000, 0, 1, 32'h2800, 1, 1);
        iss(32'h410, i_ins(5'h01, 5'h01, 12'h000), 32'h5002, 0, 1, 32'h5002, 1, 0);
        for (int i = 0; i < 6; i++) begin
            iss(32'h800, b_ins(f3s[i], 13'h1FFC), 32'hFFFF_FFFF, 32'h1, TK_NEG[i], 32'h7FC, 0, 0);
            iss(32'h800, b_ins(f3s[i], 13'h0006), 32'h5, 32'h5, TK_EQ[i], 32'h806, 0, 0);
        end
        `CHK(irq, 1'b0)
        apb(1'b1, ADDR_MASK, 32'h3);
        repeat (2) @(posedge pclk);
        #1 `CHK(irq, 1'b1)
        rd(ADDR_MASK, 32'h3);
        rd(ADDR_STATUS, 32'h3);
        repeat (2) @(posedge pclk);
        #1 `CHK(irq, 1'b0)
        rd(ADDR_STATUS, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h3);
        hw_mode = 1'b1;
        iss(32'h600, j_ins(ZERO_REG, 21'h6), 0, 0, 1, 32'h606, 0, 0);
        iss(32'h800, b_ins(F3_NE, 13'h0006), 32'h1, 32'h2, 1, 32'h806, 0, 0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        hw_mode = 1'b0;
        fault_arm <= 1'b1;
        iss(32'h900, j_ins(ZERO_REG, 21'h40), 0, 0, 1, 32'h940, 0, 0);
        repeat (2) @(posedge pclk);
        #1 `CHK({fault_valid, fault_pc}, {1'b1, 32'h940})
        fault_arm <= 1'b0;
        rd(ADDR_STATUS, 32'h5);
        rd(ADDR_COUNT, 32'(n_clean));
        tally_and_finish();
    end
endmodule
`default_nettype wire
